// ---- rtl/timer01_counter_timer.sv ----
// Purpose: Two counter/timers with 13, 16, 8-bit reload and split modes
// Assumes: AHB-Lite slave, single word transfers, 20 MHz clk_i
// Notes:   Reads take one wait state, writes none; response is always OKAY
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
//
// Overview of operation
// RQ1: Each timer picks its own mode independently
// RQ2: Count is 16 bits as low and high bytes
// RQ3: Counter select counts falling edges on event pin
// RQ4: Otherwise system clock or prescaled clock by source bit
// RQ5: Prescaled clock derived from two-bit scale field
// RQ6: Events up to quarter system clock are counted
// RQ7: Event source holds each level two clocks
// RQ8: 13-bit mode uses high byte and low five
// RQ9: 13-bit wrap sets flag, may interrupt
// RQ10: Count only when run and gate allow
// RQ11: Run bit never clears or preloads count
// RQ12: Software loads count before setting run
// RQ13: Timer 1 mirrors timer 0 with gate input b
// RQ14: Mode 1 counts through all 16 bits
// RQ15: Mode 2 reloads low byte from high on wrap
// RQ16: Interrupt is flag gated by enable bit
// RQ17: Mode 3 splits timer 0 into two bytes
// RQ18: Split high byte uses timer 1 run and flag
// RQ19: Timer 1 mode 3 stops; split restricts timer 1
// RQ20: Flag cleared by software or vector acknowledge
// RQ21: Mode codes 00, 01, 10, 11 are modes 0-3
module timer01_counter_timer
  import timer01_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Pins
  input  wire logic        timer0_event_pin_i,
  input  wire logic        timer1_event_pin_i,
  input  wire logic        gate_input_a_i,
  input  wire logic        gate_input_b_i,
  // Interrupt vector acknowledge
  input  wire logic        timer0_irq_ack_i,
  input  wire logic        timer1_irq_ack_i,
  // Requests and overflow
  output logic             timer0_irq_o,
  output logic             timer1_irq_o,
  output logic             timer1_overflow_o
);
  // Registers
  logic [7:0] timer_control_reg, next_control;
  logic [7:0] timer_mode_reg, next_mode;
  logic [7:0] clock_control_reg, next_clock;
  logic [7:0] ext_irq_config_reg, next_ext_cfg;
  logic [7:0] irq_enable_reg, next_irq_en;
  logic [7:0] timer0_count_low, next_t0_low;
  logic [7:0] timer0_count_high, next_t0_high;
  logic [7:0] timer1_count_low, next_t1_low;
  logic [7:0] timer1_count_high, next_t1_high;
  logic       next_t0_irq, next_t1_irq, next_t1_ovf;
  // Bus slave state
  bus_state_t bus_state, next_bus_state;
  logic       wr_pend, next_wr_pend;
  logic [7:0] acc_addr, next_acc_addr;
  logic [31:0] next_hrdata;
  logic       next_hreadyout;
  // Pin synchronisers: stage one is read only by stage two
  logic [3:0] pin_meta, pin_sync;
  logic [1:0] ev_prev;
  // Timebase
  logic       presc_tick;

  timer01_prescaler u_prescaler (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .scale_i   (clock_control_reg[BIT_PRESC_LSB +: 2]),
    .tick_o    (presc_tick)
  );

  // One step of a counter: returns {overflow, high, low}
  function automatic logic [16:0] count_step(input timer_mode_t mode,
                                             input logic [7:0] low,
                                             input logic [7:0] high);
    logic [16:0] res;
    logic [12:0] c13;
    logic [15:0] c16;
    res = {1'b0, high, low};
    c13 = {high, low[4:0]} + 13'd1;
    c16 = {high, low} + 16'd1;
    case (mode)
      MODE_13BIT: begin
        // Bits 7..5 of the low byte are left as they were
        res = {({high, low[4:0]} == 13'h1fff), c13[12:5], low[7:5], c13[4:0]}; // RQ8 RQ9
      end
      MODE_16BIT: begin
        res = {({high, low} == 16'hffff), c16}; // RQ14
      end
      MODE_RELOAD: begin
        if (low == 8'hff) begin
          res = {1'b1, high, high}; // RQ15
        end else begin
          res = {1'b0, high, low + 8'd1};
        end
      end
      default: begin
        // Split mode, low byte as free 8-bit counter
        res = {(low == 8'hff), high, low + 8'd1}; // RQ17
      end
    endcase
    return res;
  endfunction

  // Read decode, unmapped addresses read zero
  function automatic logic [7:0] read_mux(input logic [7:0] addr);
    logic [7:0] d;
    case (addr)
      OFS_CONTROL: d = timer_control_reg;
      OFS_MODE:    d = timer_mode_reg;
      OFS_CLOCK:   d = clock_control_reg;
      OFS_EXT_CFG: d = ext_irq_config_reg;
      OFS_IRQ_EN:  d = irq_enable_reg;
      OFS_T0_LOW:  d = timer0_count_low; // RQ2
      OFS_T0_HIGH: d = timer0_count_high;
      OFS_T1_LOW:  d = timer1_count_low;
      OFS_T1_HIGH: d = timer1_count_high;
      default:     d = 8'h00;
    endcase
    return d;
  endfunction

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      ev_prev  <= 2'b00;
    end else begin
      pin_meta <= {gate_input_b_i, gate_input_a_i, timer1_event_pin_i, timer0_event_pin_i};
      pin_sync <= pin_meta;
      ev_prev  <= pin_sync[1:0];
    end
  end

  always_comb begin
    timer_mode_t mode0;
    timer_mode_t mode1;
    logic        split;
    logic        ev0_fall;
    logic        ev1_fall;
    logic        gate_a_on;
    logic        gate_b_on;
    logic        src0;
    logic        src1;
    logic        src0_high;
    logic        run1;
    logic        tick0;
    logic        tick0_high;
    logic        tick1;
    logic        set_f0;
    logic        set_f1;
    logic [16:0] st0;
    logic [16:0] st1;
    logic [8:0]  st0_high;
    logic        acc;
    mode0      = timer_mode_t'(timer_mode_reg[BIT_MODE_LSB +: 2]); // RQ1 RQ21
    mode1      = timer_mode_t'(timer_mode_reg[MODE_T1_BASE + BIT_MODE_LSB +: 2]);
    split      = (mode0 == MODE_SPLIT);
    // Falling edges seen on synchronised samples; min level of two clocks
    ev0_fall   = ev_prev[0] & ~pin_sync[0]; // RQ3 RQ6 RQ7
    ev1_fall   = ev_prev[1] & ~pin_sync[1];
    gate_a_on  = (pin_sync[2] == ext_irq_config_reg[BIT_GATE_A_POL]);
    gate_b_on  = (pin_sync[3] == ext_irq_config_reg[BIT_GATE_B_POL]); // RQ13
    src0       = timer_mode_reg[BIT_CNT_SEL] ? ev0_fall
               : (clock_control_reg[BIT_T0_CLKSRC] | presc_tick); // RQ4
    src0_high  = clock_control_reg[BIT_T0_CLKSRC] | presc_tick;
    // Split mode denies timer 1 its external clock
    src1       = (timer_mode_reg[MODE_T1_BASE + BIT_CNT_SEL] & ~split) ? ev1_fall
               : (clock_control_reg[BIT_T1_CLKSRC] | presc_tick); // RQ19
    tick0      = timer_control_reg[BIT_T0_RUN] & src0
               & (~timer_mode_reg[BIT_GATE] | gate_a_on); // RQ10
    tick0_high = split & timer_control_reg[BIT_T1_RUN] & src0_high; // RQ18
    // Under split, timer 1 ignores its run bit; its mode and gate still apply
    run1       = split ? 1'b1 : timer_control_reg[BIT_T1_RUN];
    tick1      = (mode1 != MODE_SPLIT) & run1 & src1
               & (~timer_mode_reg[MODE_T1_BASE + BIT_GATE] | gate_b_on); // RQ13 RQ19
    st0        = count_step(mode0, timer0_count_low, timer0_count_high);
    st1        = count_step(mode1, timer1_count_low, timer1_count_high);
    st0_high   = {1'b0, timer0_count_high} + 9'd1;
    set_f0     = tick0 & st0[16]; // RQ9
    set_f1     = (tick1 & st1[16] & ~split) | (tick0_high & st0_high[8]); // RQ18

    // Counting; the run bit never touches the count
    next_t0_low  = timer0_count_low; // RQ11
    next_t0_high = timer0_count_high;
    next_t1_low  = timer1_count_low;
    next_t1_high = timer1_count_high;
    if (tick0) begin
      next_t0_low = st0[7:0];
      if (!split) begin
        next_t0_high = st0[15:8];
      end
    end
    if (tick0_high) begin
      next_t0_high = st0_high[7:0]; // RQ17
    end
    if (tick1) begin
      next_t1_low  = st1[7:0];
      next_t1_high = st1[15:8];
    end
    next_t1_ovf    = tick1 & st1[16]; // RQ19

    next_control   = timer_control_reg;
    next_mode      = timer_mode_reg;
    next_clock     = clock_control_reg;
    next_ext_cfg   = ext_irq_config_reg;
    next_irq_en    = irq_enable_reg;
    next_bus_state = bus_state;
    next_wr_pend   = 1'b0;
    next_acc_addr  = acc_addr;
    next_hrdata    = hrdata_o;
    next_hreadyout = hreadyout_o;

    // Data phase of a write; a software write wins over counting
    if (wr_pend) begin
      case (acc_addr)
        OFS_CONTROL: next_control = hwdata_i[7:0];
        OFS_MODE:    next_mode    = hwdata_i[7:0];
        OFS_CLOCK:   next_clock   = hwdata_i[7:0];
        OFS_EXT_CFG: next_ext_cfg = hwdata_i[7:0];
        OFS_IRQ_EN:  next_irq_en  = hwdata_i[7:0];
        OFS_T0_LOW:  next_t0_low  = hwdata_i[7:0]; // RQ2 RQ12
        OFS_T0_HIGH: next_t0_high = hwdata_i[7:0];
        OFS_T1_LOW:  next_t1_low  = hwdata_i[7:0];
        OFS_T1_HIGH: next_t1_high = hwdata_i[7:0];
        default:     next_control = next_control;
      endcase
    end
    // Flags: acknowledge clears, but a new overflow in the same cycle wins
    if (timer0_irq_ack_i) begin
      next_control[BIT_T0_FLAG] = 1'b0; // RQ20
    end
    if (timer1_irq_ack_i) begin
      next_control[BIT_T1_FLAG] = 1'b0; // RQ20
    end
    if (set_f0) begin
      next_control[BIT_T0_FLAG] = 1'b1;
    end
    if (set_f1) begin
      next_control[BIT_T1_FLAG] = 1'b1;
    end
    next_t0_irq = next_control[BIT_T0_FLAG] & next_irq_en[BIT_T0_IRQ_EN]; // RQ16
    next_t1_irq = next_control[BIT_T1_FLAG] & next_irq_en[BIT_T1_IRQ_EN]; // RQ16

    // Address phase; reads wait one cycle so a prior write lands first
    acc = hsel_i & htrans_i[1] & hready_i;
    case (bus_state)
      BUS_IDLE: begin
        if (acc) begin
          next_acc_addr = haddr_i[7:0];
          if (hwrite_i) begin
            next_wr_pend = 1'b1;
          end else begin
            next_hreadyout = 1'b0;
            next_bus_state = BUS_READ;
          end
        end
      end
      BUS_READ: begin
        next_hrdata    = {24'h000000, read_mux(acc_addr)};
        next_hreadyout = 1'b1;
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_hreadyout = 1'b1;
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_control_reg  <= RST_BYTE;
      timer_mode_reg     <= RST_BYTE;
      clock_control_reg  <= RST_BYTE;
      ext_irq_config_reg <= RST_BYTE;
      irq_enable_reg     <= RST_BYTE;
      timer0_count_low   <= RST_BYTE;
      timer0_count_high  <= RST_BYTE;
      timer1_count_low   <= RST_BYTE;
      timer1_count_high  <= RST_BYTE;
      timer0_irq_o       <= 1'b0;
      timer1_irq_o       <= 1'b0;
      timer1_overflow_o  <= 1'b0;
      bus_state          <= BUS_IDLE;
      wr_pend            <= 1'b0;
      acc_addr           <= 8'h00;
      hrdata_o           <= 32'h00000000;
      hreadyout_o        <= 1'b1;
      hresp_o            <= 1'b0;
    end else begin
      timer_control_reg  <= next_control;
      timer_mode_reg     <= next_mode;
      clock_control_reg  <= next_clock;
      ext_irq_config_reg <= next_ext_cfg;
      irq_enable_reg     <= next_irq_en;
      timer0_count_low   <= next_t0_low;
      timer0_count_high  <= next_t0_high;
      timer1_count_low   <= next_t1_low;
      timer1_count_high  <= next_t1_high;
      timer0_irq_o       <= next_t0_irq;
      timer1_irq_o       <= next_t1_irq;
      timer1_overflow_o  <= next_t1_ovf;
      bus_state          <= next_bus_state;
      wr_pend            <= next_wr_pend;
      acc_addr           <= next_acc_addr;
      hrdata_o           <= next_hrdata;
      hreadyout_o        <= next_hreadyout;
      hresp_o            <= 1'b0;
    end
  end
endmodule

// ---- rtl/timer01_pkg.sv ----
// Purpose: Shared constants for the timer 0/1 counter/timer block
// Assumes: AHB-Lite word registers, 8-bit data in the low byte
// Notes:   Offsets are byte addresses; upper data bits read as zero
package timer01_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_MODE     = 8'h04;
  localparam logic [7:0] OFS_CLOCK    = 8'h08;
  localparam logic [7:0] OFS_EXT_CFG  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h10;
  localparam logic [7:0] OFS_T0_LOW   = 8'h14;
  localparam logic [7:0] OFS_T0_HIGH  = 8'h18;
  localparam logic [7:0] OFS_T1_LOW   = 8'h1c;
  localparam logic [7:0] OFS_T1_HIGH  = 8'h20;
  // Control register fields
  localparam int BIT_T1_FLAG = 7;
  localparam int BIT_T1_RUN  = 6;
  localparam int BIT_T0_FLAG = 5;
  localparam int BIT_T0_RUN  = 4;
  // Mode register fields, timer 1 sits four bits above timer 0
  localparam int MODE_T1_BASE = 4;
  localparam int BIT_GATE     = 3;
  localparam int BIT_CNT_SEL  = 2;
  localparam int BIT_MODE_LSB = 0;
  // Clock control fields
  localparam int BIT_T1_CLKSRC = 4;
  localparam int BIT_T0_CLKSRC = 3;
  localparam int BIT_PRESC_LSB = 0;
  // External gate configuration fields
  localparam int BIT_GATE_B_POL = 7;
  localparam int BIT_GATE_A_POL = 3;
  // Interrupt enable fields
  localparam int BIT_T1_IRQ_EN = 3;
  localparam int BIT_T0_IRQ_EN = 1;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Prescale divide ratios for field codes 00, 01, 10, 11
  localparam logic [5:0] DIV_CODE0 = 6'd12;
  localparam logic [5:0] DIV_CODE1 = 6'd4;
  localparam logic [5:0] DIV_CODE2 = 6'd48;
  localparam logic [5:0] DIV_CODE3 = 6'd8;
  // Timer modes
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } timer_mode_t;
  // Bus slave states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_READ = 1'b1
  } bus_state_t;
endpackage

// ---- rtl/timer01_prescaler.sv ----
// Purpose: Prescaled timebase enable for the timers
// Assumes: One clock; output is a one-cycle enable pulse
// Notes:   A new divide ratio takes effect at once, compared against the running count
`timescale 1ns/100ps
module timer01_prescaler
  import timer01_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Control
  input  wire logic [1:0] scale_i,
  // Timebase
  output logic            tick_o
);
  logic [5:0] div_cnt;
  logic [5:0] next_div_cnt;
  logic       next_tick;
  logic [5:0] ratio;

  always_comb begin
    case (scale_i)
      2'b00:   ratio = DIV_CODE0;
      2'b01:   ratio = DIV_CODE1;
      2'b10:   ratio = DIV_CODE2;
      default: ratio = DIV_CODE3;
    endcase
    next_tick    = 1'b0;
    next_div_cnt = div_cnt + 6'd1;
    if (div_cnt >= ratio - 6'd1) begin // RQ5
      next_div_cnt = 6'd0;
      next_tick    = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_cnt <= 6'd0;
      tick_o  <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick_o  <= next_tick;
    end
  end
endmodule

// ---- bench/timer01_counter_timer_monitor.sv ----
// Purpose: Port checks on bus timing and interrupt requests
// Assumes: One clock, hready_i tied to hreadyout_o
// Notes:   Acknowledge checks assume no overflow lands on the same edge
`timescale 1ns/100ps
module timer01_monitor (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // Bus
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  // Interrupts
  input wire logic        timer0_irq_ack_i,
  input wire logic        timer1_irq_ack_i,
  input wire logic        timer0_irq_o,
  input wire logic        timer1_irq_o
);
  logic rd;
  logic wr;
  assign rd = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
  assign wr = hsel_i & htrans_i[1] & hready_i & hwrite_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_resp_okay: assert property (hresp_o == 1'b0) else $error("bus response not okay");
  a_write_no_wait: assert property (wr |=> hreadyout_o) else $error("write stalled");
  a_read_one_wait: assert property (rd |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  a_rdata_upper_zero: assert property (hrdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_rdata_hold: assert property (!rd |-> ##2 $stable(hrdata_o)) else $error("read data moved");
  a_unmapped_zero: assert property (rd && haddr_i[7:0] > 8'h20 |-> ##2 hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_irq0_level_hold: assert property (timer0_irq_o && !timer0_irq_ack_i &&
    !$past(wr) |=> timer0_irq_o) else $error("timer0 request dropped");
  a_irq0_ack_clear: assert property (timer0_irq_ack_i |-> ##2 !timer0_irq_o)
    else $error("timer0 request not cleared");
  a_irq1_ack_clear: assert property (timer1_irq_ack_i |-> ##2 !timer1_irq_o)
    else $error("timer1 request not cleared");
endmodule
bind timer01_counter_timer timer01_monitor u_timer01_monitor (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .timer0_irq_ack_i(timer0_irq_ack_i), .timer1_irq_ack_i(timer1_irq_ack_i),
  .timer0_irq_o(timer0_irq_o), .timer1_irq_o(timer1_irq_o));

// ---- bench/timer01_counter_timer_test.sv ----
// Purpose: Self-checking bench for the timer 0/1 block
// Assumes: Gate and event inputs see equal synchroniser delay on both edges
// Notes:   Split mode is checked with one short hand-made window
`timescale 1ns/100ps
`define CHECK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module timer01_counter_timer_test;
  import timer01_pkg::*;
  logic        clk_i = 0;
  logic        sys_rst_i = 1;
  logic        hsel_i = 0;
  logic        hwrite_i = 0;
  logic [1:0]  htrans_i = 0;
  logic [31:0] haddr_i = 0;
  logic [31:0] hwdata_i = 0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        ev0 = 1;
  logic        ga = 0;
  logic        gb = 0;
  logic        ack0 = 0;
  logic        ack1 = 0;
  logic        irq0;
  logic        irq1;
  logic        t1ovf;
  int          n_ovf = 0;
  logic [31:0] lfsr = 32'd96192;
  logic [7:0]  rd;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  timer01_counter_timer u_timer01_counter_timer (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(3'b010), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(), .timer0_event_pin_i(ev0),
    .timer1_event_pin_i(1'b1), .gate_input_a_i(ga), .gate_input_b_i(gb),
    .timer0_irq_ack_i(ack0), .timer1_irq_ack_i(ack1), .timer0_irq_o(irq0),
    .timer1_irq_o(irq1), .timer1_overflow_o(t1ovf));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (t1ovf === 1'b1) n_ovf++;
  end
  task automatic stop_test();
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, generous against the thousand or so cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // Reference count: {flag, high, low} after k ticks
  function automatic logic [16:0] model(input logic [1:0] m, input logic [7:0] hi,
                                        input logic [7:0] lo, input int k);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    repeat (k) begin
      if (m == 2'd2) begin
        r[7:0] = r[7:0] + 8'h01;
        if (r[7:0] == 8'h00) r = {1'b1, r[15:8], r[15:8]};
      end else if (m == 2'd1) begin
        r[15:0] = r[15:0] + 16'h0001;
        if (r[15:0] == 16'h0000) r[16] = 1'b1;
      end else begin
        {r[15:8], r[4:0]} = {r[15:8], r[4:0]} + 13'h0001;
        if ({r[15:8], r[4:0]} == 13'h0000) r[16] = 1'b1;
      end
    end
    return r;
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    hwrite_i <= w;
    haddr_i <= {24'h0, a};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= {24'h0, d};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o[7:0];
  endtask
  task automatic pulse_event();
    ev0 <= 1'b0;
    repeat (2) @(posedge clk_i);
    ev0 <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask
  // Gate window of n cycles on timer t, k ticks expected inside it
  task automatic run(input logic t, input logic [1:0] m, input int n, input int k,
                     input logic [7:0] clk_cfg);
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [16:0] e;
    hi = (m == 2'd2) ? rnd() : 8'hff;
    lo = 8'he0 | rnd();
    e = model(m, hi, lo, k);
    bus(1, OFS_CONTROL, 8'h00);
    bus(1, OFS_MODE, {4'h0, 2'b10, m} << (t * 4));
    bus(1, OFS_CLOCK, clk_cfg);
    bus(1, OFS_EXT_CFG, 8'h88);
    bus(1, OFS_IRQ_EN, 8'h0a);
    bus(1, t ? OFS_T1_LOW : OFS_T0_LOW, lo);
    bus(1, t ? OFS_T1_HIGH : OFS_T0_HIGH, hi);
    n_ovf = 0;
    bus(1, OFS_CONTROL, t ? 8'h40 : 8'h10);
    if (t) gb <= 1'b1;
    else ga <= 1'b1;
    repeat (n) @(posedge clk_i);
    ga <= 1'b0;
    gb <= 1'b0;
    repeat (8) @(posedge clk_i);
    bus(0, t ? OFS_T1_LOW : OFS_T0_LOW, 8'h00);
    if (m == 2'd0) `CHECK("count low", e[4:0], rd[4:0])
    else `CHECK("count low", e[7:0], rd)
    bus(0, t ? OFS_T1_HIGH : OFS_T0_HIGH, 8'h00);
    `CHECK("count high", e[15:8], rd)
    bus(0, OFS_CONTROL, 8'h00);
    `CHECK("control", {e[16] & t, t, e[16] & !t, !t, 4'h0}, rd)
    `CHECK("irq", e[16], t ? irq1 : irq0)
    `CHECK("overflow pulse", e[16] & t, n_ovf != 0)
    if (t) ack1 <= 1'b1;
    else ack0 <= 1'b1;
    @(posedge clk_i);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    repeat (3) @(posedge clk_i);
    bus(0, OFS_CONTROL, 8'h00);
    `CHECK("flag after ack", {1'b0, t, 1'b0, !t, 4'h0}, rd)
    $display("timer %0d mode %0d window %0d done", t, m, n);
  endtask
  initial begin
    logic [7:0] v;
    int         n;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int a = 0; a <= 8'h24; a += 4) begin
      bus(0, a[7:0], 8'h00);
      `CHECK("reset value", RST_BYTE, rd)
      v = rnd();
      // Keep both timers stopped so counts stay put during the sweep
      if (a == 0) v = v & 8'h0f;
      if (a == 4) v[0] = 1'b0;
      bus(1, a[7:0], v);
      bus(0, a[7:0], 8'h00);
      if (a > 0) `CHECK("readback", (a > 8'h20) ? 8'h00 : v, rd)
    end
    $display("register access test done");
    for (int i = 0; i < 6; i++) begin
      n = 1 + rnd() % 40;
      run(i % 2, i / 2, n, n, 8'h18);
    end
    // Any window of 2*div cycles holds exactly two prescaled ticks
    run(0, 1, 2 * DIV_CODE0, 2, 8'h00);
    run(0, 1, 2 * DIV_CODE1, 2, 8'h01);
    run(0, 1, 2 * DIV_CODE2, 2, 8'h02);
    run(0, 1, 2 * DIV_CODE3, 2, 8'h03);
    // Split: three ticks between the run and stop writes, last wrap meets the stop write
    bus(1, OFS_CONTROL, 8'h00);
    bus(1, OFS_T0_LOW, 8'hfd);
    bus(1, OFS_T0_HIGH, 8'hfd);
    bus(1, OFS_CLOCK, 8'h18);
    bus(1, OFS_MODE, 8'h03);
    bus(1, OFS_CONTROL, 8'h50);
    bus(1, OFS_CONTROL, 8'h00);
    bus(0, OFS_T0_LOW, 8'h00);
    `CHECK("split low", 8'h00, rd)
    bus(0, OFS_T0_HIGH, 8'h00);
    `CHECK("split high", 8'h00, rd)
    bus(0, OFS_CONTROL, 8'h00);
    `CHECK("split flags", 8'ha0, rd)
    $display("split mode test done");
    bus(1, OFS_CONTROL, 8'h00);
    bus(1, OFS_T0_LOW, 8'h00);
    bus(1, OFS_T0_HIGH, 8'h00);
    bus(1, OFS_MODE, 8'h05);
    repeat (3) pulse_event();
    bus(1, OFS_CONTROL, 8'h10);
    repeat (5) pulse_event();
    repeat (6) @(posedge clk_i);
    bus(0, OFS_T0_LOW, 8'h00);
    `CHECK("event count", 8'h05, rd)
    $display("event counting test done");
    stop_test();
  end
endmodule
